/* wwdg_pkg.sv */
// package: register map, field layout and types of the windowed watchdog
`default_nettype none
package wwdg_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_CONTROL_CONFIG = 12'h000;
	localparam logic [11:0] OFS_COUNTER_CLEAR = 12'h004;
	localparam logic [11:0] OFS_STATE_FLAGS = 12'h008;
	localparam logic [11:0] OFS_MODULE_REVISION = 12'h3fc;
	// reset values
	localparam logic [31:0] RST_CONTROL_CONFIG = 32'h00010080;
	localparam logic [31:0] RST_STATE_FLAGS = 32'h00000003;
	// arbitrary revision value, no meaning
	localparam logic [31:0] REVISION_VALUE = 32'h00000123;
	// key field and key values
	localparam int KEY_LSB = 24;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// control, clear and state flag field positions
	localparam int BIT_EN = 0;
	localparam int BIT_DAR = 1;
	localparam int BIT_MODE = 2;
	localparam int BIT_LOCK = 3;
	localparam int BIT_FCD = 7;
	localparam int PSEL_LSB = 8;
	localparam int BIT_CEN = 16;
	localparam int BIT_COUNT_CLOCK_SOURCE = 17;
	localparam int TBAN_LSB = 18;
	localparam int BIT_CLEAR_REQ = 0;
	localparam int BIT_CLEARED = 1;
	localparam int BIT_WINDOW = 0;
	// timeout select loaded by the autostart fuse, above 100 ms on the rc osc
	localparam logic [4:0] PSEL_AUTOSTART = 5'h10;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} wwdg_ahb_req_s;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} wwdg_ahb_rsp_s;

	typedef struct packed {
		logic en_req;
		logic en_act;
		logic disable_after_wd_reset;
		logic mode;
		logic lock;
		logic fcd;
		logic [4:0] psel;
		logic count_clock_enable;
		logic count_clock_source;
		logic [4:0] tban;
	} wwdg_ctrl_s;

	typedef struct packed {
		wwdg_ctrl_s ctrl;
		logic boot;
		logic ctrl_armed;
		logic [23:0] ctrl_first;
		logic clr_armed;
		logic cleared;
		logic clr_pend;
		logic [31:0] cnt;
		logic rst_req;
		logic cal_req;
		logic dph_wr;
		logic [11:0] dph_addr;
		logic [31:0] rdata;
	} wwdg_state_s;
endpackage
`default_nettype wire

/* wwdg_top.sv */
// windowed watchdog with keyed registers on an ahb-lite slave port
//
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none
// Function
// RULE_01 - no disable flag: restart count after trip
// RULE_02 - disable flag: trip clears only enable (any trip here also clears lock)
// RULE_03 - fuse and no calibration: ignore disable flag
// RULE_04 - mode bit: basic/window, frozen while enabled
// RULE_05 - window timeout is ban plus timeout
// RULE_06 - clear inside ban period trips reset
// RULE_07 - clear in window restarts count
// RULE_08 - accepted control change clears counter
// RULE_09 - counter at total timeout trips reset
// RULE_10 - software disables by enable only
// RULE_11 - stopped count clock blocks disable readback
// RULE_12 - fuse autostart: basic, rc osc, long timeout
// RULE_13 - trip without calibration flag recalibrates
// RULE_14 - other resets always recalibrate
// RULE_15 - lock bit blocks control writes
// RULE_16 - control write needs 55 then aa
// RULE_17 - clear needs keyed pair with bit
// RULE_18 - source select: rc osc or crystal
// RULE_19 - count clock enable gates counting
// RULE_20 - enable readback follows counting domain
// RULE_21 - software clears periodically in window
// RULE_22 - software picks timeout above startup
// RULE_23 - basic timeout is two power psel+1
// RULE_24 - cleared flag drops, rises, gates clears
// RULE_25 - window flag low in ban period
// RULE_26 - other reset: count clock on, rc
// RULE_27 - bus to count domain crossing synchronised
// RULE_28 - reset request held one count tick
module wwdg_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register bus
	input wire wwdg_pkg::wwdg_ahb_req_s ahb_req,
	output wwdg_pkg::wwdg_ahb_rsp_s ahb_rsp,
	// count clock ticks, one cycle pulses
	input wire logic system_rc_osc_tick,
	input wire logic slow_crystal_osc_tick,
	// fuse and flash calibration
	input wire logic autostart_fuse,
	input wire logic flash_cal_finish,
	output logic flash_cal_request,
	// to power manager
	output logic watchdog_reset_request
);
	////////////////////////////////////////////////////////////////////////
	wwdg_pkg::wwdg_state_s s_q;
	wwdg_pkg::wwdg_state_s s_d;
	logic tick;
	logic addr_ph;
	logic [33:0] ban_len;
	logic [33:0] psel_len;
	logic [33:0] total_len;
	logic [33:0] cnt_next;
	logic in_ban;
	logic [31:0] ctrl_rd;
	logic [31:0] wd;
	logic [7:0] key;
	logic ctrl_ok;
	logic clr_ok;
	logic trip;

	////////////////////////////////////////////////////////////////////////
	// count clock selection and gating
	assign tick = s_q.ctrl.count_clock_enable && (s_q.ctrl.count_clock_source ? // RULE_18 RULE_19
		slow_crystal_osc_tick : system_rc_osc_tick);

	// period lengths, wide enough for a select of 31
	assign ban_len = 34'h1 << (6'(s_q.ctrl.tban) + 6'h1); // RULE_05
	assign psel_len = 34'h1 << (6'(s_q.ctrl.psel) + 6'h1); // RULE_23
	assign total_len = s_q.ctrl.mode ? ban_len + psel_len : psel_len;
	assign cnt_next = {2'h0, s_q.cnt} + 34'h1;
	assign in_ban = s_q.ctrl.mode && ({2'h0, s_q.cnt} < ban_len); // RULE_25

	// readback: enable shows the counting domain, key reads zero
	assign ctrl_rd = {8'h00, 1'b0, s_q.ctrl.tban, s_q.ctrl.count_clock_source,
		s_q.ctrl.count_clock_enable, 3'h0, s_q.ctrl.psel, s_q.ctrl.fcd, 3'h0,
		s_q.ctrl.lock, s_q.ctrl.mode, s_q.ctrl.disable_after_wd_reset,
		s_q.ctrl.en_act}; // RULE_16 RULE_20

	assign addr_ph = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
	assign wd = ahb_req.hwdata;
	assign key = wd[wwdg_pkg::KEY_LSB +: 8];
	assign ctrl_ok = s_q.dph_wr
		&& s_q.dph_addr == wwdg_pkg::OFS_CONTROL_CONFIG
		&& s_q.ctrl_armed && key == wwdg_pkg::KEY_SECOND
		&& wd[23:0] == s_q.ctrl_first && !s_q.ctrl.lock; // RULE_15 RULE_16
	assign clr_ok = s_q.dph_wr
		&& s_q.dph_addr == wwdg_pkg::OFS_COUNTER_CLEAR
		&& s_q.clr_armed && key == wwdg_pkg::KEY_SECOND
		&& wd[wwdg_pkg::BIT_CLEAR_REQ]; // RULE_17
	assign trip = tick && s_q.ctrl.en_act && ((s_q.clr_pend && in_ban)
		|| (!s_q.clr_pend && cnt_next >= total_len)); // RULE_06 RULE_09

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.boot = 1'b0;
		// autostart at the first edge after release
		if (s_q.boot && autostart_fuse) begin
			s_d.ctrl.en_req = 1'b1; // RULE_12
			s_d.ctrl.en_act = 1'b1;
			s_d.ctrl.mode = 1'b0;
			s_d.ctrl.count_clock_source = 1'b0;
			s_d.ctrl.psel = wwdg_pkg::PSEL_AUTOSTART;
		end
		// bus data phase
		if (s_q.dph_wr && s_q.dph_addr == wwdg_pkg::OFS_CONTROL_CONFIG) begin
			s_d.ctrl_armed = key == wwdg_pkg::KEY_FIRST;
			s_d.ctrl_first = wd[23:0];
		end
		if (s_q.dph_wr && s_q.dph_addr == wwdg_pkg::OFS_COUNTER_CLEAR) begin
			s_d.clr_armed = key == wwdg_pkg::KEY_FIRST
				&& wd[wwdg_pkg::BIT_CLEAR_REQ];
		end
		if (ctrl_ok) begin
			s_d.ctrl.en_req = wd[wwdg_pkg::BIT_EN];
			if (!(autostart_fuse && !s_q.ctrl.fcd
				&& wd[wwdg_pkg::BIT_DAR])) begin
				s_d.ctrl.disable_after_wd_reset = wd[wwdg_pkg::BIT_DAR]; // RULE_03
			end
			if (!s_q.ctrl.en_act) begin
				s_d.ctrl.mode = wd[wwdg_pkg::BIT_MODE]; // RULE_04
			end
			s_d.ctrl.lock = wd[wwdg_pkg::BIT_LOCK]; // RULE_15
			s_d.ctrl.psel = wd[wwdg_pkg::PSEL_LSB +: 5];
			s_d.ctrl.count_clock_enable = wd[wwdg_pkg::BIT_CEN]; // RULE_19
			s_d.ctrl.count_clock_source = wd[wwdg_pkg::BIT_COUNT_CLOCK_SOURCE];
			s_d.ctrl.tban = wd[wwdg_pkg::TBAN_LSB +: 5];
			// counter restarts without a reset, unless a trip falls in the same cycle
			s_d.cnt = 32'h0; // RULE_08
			s_d.clr_pend = 1'b0;
			s_d.cleared = 1'b1;
		end
		// a clear is taken only while the previous one is finished
		if (clr_ok && s_q.cleared) begin
			s_d.cleared = 1'b0; // RULE_24
			s_d.clr_pend = 1'b1; // RULE_27
		end
		// counting domain: enable and clear take effect on a count tick
		if (tick) begin
			s_d.ctrl.en_act = s_q.ctrl.en_req; // RULE_11 RULE_20 RULE_27
			s_d.rst_req = 1'b0; // RULE_28
			if (s_q.ctrl.en_act && !ctrl_ok) begin
				s_d.cnt = s_q.cnt + 32'h1;
			end
			if (s_q.clr_pend) begin
				s_d.cnt = 32'h0; // RULE_07
				s_d.clr_pend = 1'b0;
				s_d.cleared = 1'b1; // RULE_24
			end
		end
		// watchdog trip: counter and lock cleared, enable cleared under the disable flag, rest of config kept
		if (trip) begin
			s_d.cnt = 32'h0; // RULE_01 RULE_06 RULE_09
			s_d.rst_req = 1'b1; // RULE_28
			s_d.ctrl.lock = 1'b0; // RULE_15
			s_d.ctrl_armed = 1'b0;
			s_d.clr_armed = 1'b0;
			if (s_q.ctrl.disable_after_wd_reset) begin
				s_d.ctrl.en_req = 1'b0; // RULE_02
				s_d.ctrl.en_act = 1'b0;
			end
			if (!s_q.ctrl.fcd) begin
				s_d.cal_req = 1'b1; // RULE_13
			end
		end
		if (s_q.cal_req && flash_cal_finish) begin
			s_d.cal_req = 1'b0; // RULE_13 RULE_14
			s_d.ctrl.fcd = 1'b1;
		end
		// address phase: latch and prepare read data one cycle ahead
		s_d.dph_wr = addr_ph && ahb_req.hwrite;
		s_d.dph_addr = ahb_req.haddr[11:0];
		s_d.rdata = 32'h0;
		if (addr_ph && !ahb_req.hwrite) begin
			unique case (ahb_req.haddr[11:0])
				wwdg_pkg::OFS_CONTROL_CONFIG: s_d.rdata = ctrl_rd;
				wwdg_pkg::OFS_STATE_FLAGS: begin
					s_d.rdata[wwdg_pkg::BIT_CLEARED] = s_q.cleared;
					s_d.rdata[wwdg_pkg::BIT_WINDOW] = !in_ban; // RULE_25
				end
				wwdg_pkg::OFS_MODULE_REVISION:
					s_d.rdata = wwdg_pkg::REVISION_VALUE;
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset: count clock on from rc osc, calibration requested
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.ctrl.count_clock_enable <= 1'b1; // RULE_26
			s_q.ctrl.count_clock_source <= 1'b0;
			s_q.cleared <= 1'b1;
			s_q.boot <= 1'b1;
			s_q.cal_req <= 1'b1; // RULE_14
		end else begin
			s_q <= s_d;
		end
	end

	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign ahb_rsp.hrdata = s_q.rdata;
	assign flash_cal_request = s_q.cal_req;
	assign watchdog_reset_request = s_q.rst_req;

	////////////////////////////////////////////////////////////////////////
	// reset request stays up until the next count tick
	a_rst_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(watchdog_reset_request) ##1 !tick[*1] |->
		watchdog_reset_request) // RULE_28
		else $error("reset request dropped early");

	a_trip_timeout: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		tick && s_q.ctrl.en_act && !s_q.clr_pend
		&& cnt_next >= total_len |=> watchdog_reset_request
		&& s_q.cnt == 32'h0) // RULE_09
		else $error("no reset at total timeout");

	a_ban_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick && s_q.ctrl.en_act && s_q.clr_pend && in_ban
		|=> watchdog_reset_request) // RULE_06
		else $error("clear in ban period did not trip");

	a_win_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick && s_q.ctrl.en_act && s_q.clr_pend && !in_ban && !ctrl_ok
		|=> s_q.cnt == 32'h0 && s_q.cleared
		&& !$rose(watchdog_reset_request)) // RULE_07
		else $error("window clear mishandled");

	a_ctrl_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctrl_ok && !trip |=> s_q.cnt == 32'h0
		&& !$rose(watchdog_reset_request)) // RULE_08
		else $error("control write did not clear counter");

	a_lock_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_q.ctrl.lock && !trip && !tick && !(s_q.boot && autostart_fuse)
		&& !(s_q.cal_req && flash_cal_finish) |=> $stable(s_q.ctrl)) // RULE_15
		else $error("locked control changed");

	a_mode_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_q.ctrl.en_act && !s_q.boot |=> $stable(s_q.ctrl.mode)) // RULE_04
		else $error("mode changed while enabled");

	a_en_no_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
		!tick && !trip && !s_q.boot |=> $stable(s_q.ctrl.en_act)) // RULE_20
		else $error("enable readback moved without tick");

	a_clr_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
		clr_ok && !s_q.cleared && !ctrl_ok |=> !s_q.cleared) // RULE_24
		else $error("clear taken while busy");

	a_key_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_q.rdata[31:24] == 8'h00) // RULE_16
		else $error("key field read nonzero");

	////////////////////////////////////////////////////////////////////////
	// count clock gating: a stopped clock freezes enable and count
	a_cen_stall: assert property (@(posedge sys_clk) // RULE_11
		disable iff (!resetn)
		!s_q.ctrl.count_clock_enable && !(s_q.boot && autostart_fuse)
		|=> $stable(s_q.ctrl.en_act))
		else $error("enable moved with count clock off");

	a_cen_count: assert property (@(posedge sys_clk) // RULE_19
		disable iff (!resetn)
		!s_q.ctrl.count_clock_enable && !ctrl_ok |=> $stable(s_q.cnt))
		else $error("counter moved with count clock off");

	a_sel_rc: assert property (@(posedge sys_clk) // RULE_18
		disable iff (!resetn)
		!s_q.ctrl.count_clock_source && !system_rc_osc_tick && !ctrl_ok
		|=> $stable(s_q.cnt))
		else $error("counter moved without rc tick");

	a_sel_xo: assert property (@(posedge sys_clk) // RULE_18
		disable iff (!resetn)
		s_q.ctrl.count_clock_enable && s_q.ctrl.count_clock_source && slow_crystal_osc_tick
		&& s_q.ctrl.en_act && !s_q.clr_pend && !ctrl_ok && !trip
		|=> s_q.cnt == $past(s_q.cnt) + 32'h1)
		else $error("crystal tick did not count");

	////////////////////////////////////////////////////////////////////////
	// counter bounds: an enabled count never passes the total
	a_bound_basic: assert property (@(posedge sys_clk) // RULE_23
		disable iff (!resetn)
		s_q.ctrl.en_act && !s_q.ctrl.mode
		|-> {2'h0, s_q.cnt} < (34'h1 << (6'(s_q.ctrl.psel) + 6'h1)))
		else $error("basic count beyond timeout");

	a_bound_win: assert property (@(posedge sys_clk) // RULE_05
		disable iff (!resetn)
		s_q.ctrl.en_act && s_q.ctrl.mode
		|-> {2'h0, s_q.cnt} < (34'h1 << (6'(s_q.ctrl.tban) + 6'h1))
		+ (34'h1 << (6'(s_q.ctrl.psel) + 6'h1)))
		else $error("window count beyond total");

	a_rst_clear: assert property (@(posedge sys_clk) // RULE_09
		disable iff (!resetn)
		$rose(watchdog_reset_request) |-> s_q.cnt == 32'h0)
		else $error("counter kept at reset request");

	a_rst_cause: assert property (@(posedge sys_clk) // RULE_28
		disable iff (!resetn)
		$rose(watchdog_reset_request) |-> $past(tick))
		else $error("reset request without count tick");

	////////////////////////////////////////////////////////////////////////
	// trip aftermath: disable flag, calibration, kept fields
	a_dar_off: assert property (@(posedge sys_clk) // RULE_02
		disable iff (!resetn)
		trip && s_q.ctrl.disable_after_wd_reset
		|=> !s_q.ctrl.en_act && !s_q.ctrl.en_req)
		else $error("trip with disable flag left enable");

	a_dar_others: assert property (@(posedge sys_clk) // RULE_02
		disable iff (!resetn)
		trip && !ctrl_ok |=> $stable(s_q.ctrl.psel)
		&& $stable(s_q.ctrl.tban) && $stable(s_q.ctrl.mode)
		&& $stable(s_q.ctrl.count_clock_source) && $stable(s_q.ctrl.count_clock_enable))
		else $error("trip changed a kept control field");

	a_nodar_run: assert property (@(posedge sys_clk) // RULE_01
		disable iff (!resetn)
		trip && !s_q.ctrl.disable_after_wd_reset
		|=> s_q.ctrl.en_act && s_q.cnt == 32'h0)
		else $error("trip without disable flag stopped count");

	a_cal_redo: assert property (@(posedge sys_clk) // RULE_13
		disable iff (!resetn)
		trip && !s_q.ctrl.fcd && !flash_cal_finish
		|=> flash_cal_request)
		else $error("trip did not request calibration");

	a_cal_keep: assert property (@(posedge sys_clk) // RULE_13
		disable iff (!resetn)
		trip && s_q.ctrl.fcd
		|=> $stable(flash_cal_request) && s_q.ctrl.fcd)
		else $error("calibration redone with flag set");

	a_fcd_set: assert property (@(posedge sys_clk) // RULE_14
		disable iff (!resetn)
		flash_cal_request && flash_cal_finish
		|=> s_q.ctrl.fcd && !flash_cal_request)
		else $error("calibration end not recorded");

	////////////////////////////////////////////////////////////////////////
	// state right after a bus-side reset
	a_boot_clock: assert property (@(posedge sys_clk) // RULE_26
		disable iff (!resetn)
		s_q.boot |-> s_q.ctrl.count_clock_enable && !s_q.ctrl.count_clock_source)
		else $error("count clock not on rc after reset");

	a_boot_cal: assert property (@(posedge sys_clk) // RULE_14
		disable iff (!resetn)
		s_q.boot |-> flash_cal_request && !s_q.ctrl.fcd)
		else $error("no calibration after reset");

	a_auto_start: assert property (@(posedge sys_clk) // RULE_12
		disable iff (!resetn)
		s_q.boot && autostart_fuse |=> s_q.ctrl.en_act
		&& !s_q.ctrl.mode && !s_q.ctrl.count_clock_source
		&& s_q.ctrl.psel == wwdg_pkg::PSEL_AUTOSTART)
		else $error("fuse autostart setup wrong");

	////////////////////////////////////////////////////////////////////////
	// keyed access and refusals
	a_dar_guard: assert property (@(posedge sys_clk) // RULE_03
		disable iff (!resetn)
		ctrl_ok && autostart_fuse && !s_q.ctrl.fcd && !s_q.ctrl.disable_after_wd_reset
		|=> !s_q.ctrl.disable_after_wd_reset)
		else $error("disable flag set before calibration");

	a_key_order: assert property (@(posedge sys_clk) // RULE_16
		disable iff (!resetn)
		s_q.dph_wr && s_q.dph_addr == wwdg_pkg::OFS_CONTROL_CONFIG
		&& key != wwdg_pkg::KEY_FIRST |=> !s_q.ctrl_armed)
		else $error("control pair armed without first key");

	a_lock_refuse: assert property (@(posedge sys_clk) // RULE_15
		disable iff (!resetn)
		s_q.ctrl.lock |-> !ctrl_ok)
		else $error("control write taken while locked");

	a_clr_zero: assert property (@(posedge sys_clk) // RULE_17
		disable iff (!resetn)
		s_q.dph_wr && s_q.dph_addr == wwdg_pkg::OFS_COUNTER_CLEAR
		&& !wd[wwdg_pkg::BIT_CLEAR_REQ]
		|=> !s_q.clr_armed && !$rose(s_q.clr_pend))
		else $error("clear bit zero had an effect");

	a_clear_drop: assert property (@(posedge sys_clk) // RULE_24
		disable iff (!resetn)
		clr_ok && s_q.cleared |=> !s_q.cleared && s_q.clr_pend)
		else $error("cleared flag did not drop");

	a_clear_rise: assert property (@(posedge sys_clk) // RULE_24
		disable iff (!resetn)
		tick && s_q.clr_pend |=> s_q.cleared && !s_q.clr_pend)
		else $error("cleared flag did not rise");

	a_en_sync: assert property (@(posedge sys_clk) // RULE_20
		disable iff (!resetn)
		ctrl_ok && !tick |=> $stable(s_q.ctrl.en_act))
		else $error("enable readback changed on the write");

	////////////////////////////////////////////////////////////////////////
	// status readback of the window flag
	a_win_ban: assert property (@(posedge sys_clk) // RULE_25
		disable iff (!resetn)
		addr_ph && !ahb_req.hwrite
		&& ahb_req.haddr[11:0] == wwdg_pkg::OFS_STATE_FLAGS
		&& s_q.ctrl.mode
		&& {2'h0, s_q.cnt} < (34'h1 << (6'(s_q.ctrl.tban) + 6'h1))
		|=> !ahb_rsp.hrdata[wwdg_pkg::BIT_WINDOW])
		else $error("window flag high in ban period");

	a_win_basic: assert property (@(posedge sys_clk) // RULE_25
		disable iff (!resetn)
		addr_ph && !ahb_req.hwrite
		&& ahb_req.haddr[11:0] == wwdg_pkg::OFS_STATE_FLAGS
		&& !s_q.ctrl.mode
		|=> ahb_rsp.hrdata[wwdg_pkg::BIT_WINDOW])
		else $error("window flag low in basic mode");
endmodule
`default_nettype wire

/* wwdg_far_model.sv */
// far side model: count clock ticks, flash calibration, power manager
`default_nettype none
module wwdg_far_model #(
	parameter int RC_DIV = 8,
	parameter int XO_DIV = 13,
	parameter int CAL_CYCLES = 40
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// count clock ticks
	output logic rc_tick,
	output logic xo_tick,
	// flash calibration
	input wire logic cal_request,
	output logic cal_finish,
	// power manager
	input wire logic wd_reset,
	output int trip_count
);
	timeunit 1ns;
	timeprecision 1ps;
	int rc_cnt;
	int xo_cnt;
	int cal_cnt;
	logic wd_reset_q;
	// oscillators run free; the watchdog gates them by its own enable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rc_cnt <= 0;
			xo_cnt <= 0;
			cal_cnt <= 0;
			rc_tick <= 1'b0;
			xo_tick <= 1'b0;
			cal_finish <= 1'b0;
			wd_reset_q <= 1'b0;
			trip_count <= 0;
		end else begin
			rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
			xo_cnt <= (xo_cnt == XO_DIV - 1) ? 0 : xo_cnt + 1;
			rc_tick <= (rc_cnt == RC_DIV - 1);
			xo_tick <= (xo_cnt == XO_DIV - 1);
			// slow calibration, so early control reads still see it pending
			cal_cnt <= cal_request ? cal_cnt + 1 : 0;
			cal_finish <= cal_request && (cal_cnt == CAL_CYCLES);
			wd_reset_q <= wd_reset;
			if (wd_reset && !wd_reset_q)
				trip_count <= trip_count + 1;
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
// testbench: keyed register sequences against the windowed watchdog
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC_DIV = 8;
	localparam logic [11:0] A_CTL = wwdg_pkg::OFS_CONTROL_CONFIG;
	localparam logic [11:0] A_CLR = wwdg_pkg::OFS_COUNTER_CLEAR;
	localparam logic [11:0] A_SF = wwdg_pkg::OFS_STATE_FLAGS;
	localparam logic [31:0] W = 32'h000d0484;
	logic sys_clk;
	logic resetn;
	logic fuse;
	logic rc_tick;
	logic xo_tick;
	logic cal_req;
	logic cal_fin;
	logic wd_rst;
	int trips;
	int err_total;
	int samples_checked;
	wwdg_pkg::wwdg_ahb_req_s req;
	wwdg_pkg::wwdg_ahb_rsp_s rsp;
	wwdg_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .ahb_req(req),
		.ahb_rsp(rsp), .system_rc_osc_tick(rc_tick),
		.slow_crystal_osc_tick(xo_tick), .autostart_fuse(fuse),
		.flash_cal_finish(cal_fin), .flash_cal_request(cal_req),
		.watchdog_reset_request(wd_rst));
	wwdg_far_model #(.RC_DIV(RC_DIV)) i_far (.sys_clk(sys_clk),
		.resetn(resetn), .rc_tick(rc_tick), .xo_tick(xo_tick),
		.cal_request(cal_req), .cal_finish(cal_fin), .wd_reset(wd_rst),
		.trip_count(trips));
	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req.haddr <= {20'h00000, a};
		req.htrans <= 2'h2;
		req.hwrite <= wr;
		do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
		req.htrans <= 2'h0;
		req.hwdata <= d;
		do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
		q = rsp.hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic key(input logic [11:0] a, input logic [23:0] b);
		wr(a, {wwdg_pkg::KEY_FIRST, b});
		wr(a, {wwdg_pkg::KEY_SECOND, b});
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// polls give the counting domain time to catch up with the bus
	task automatic poll(input logic [11:0] a, input string n,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		int i;
		i = 0;
		do begin
			xfer(1'b0, a, 32'h00000000, q);
			i++;
		end while ((q & m) !== e && i < 200);
		chk(n, e, q & m);
		chk("hresp", 32'h0, 32'(rsp.hresp));
	endtask
	task automatic to_trip(output int c);
		c = 0;
		while (wd_rst !== 1'b1 && c < 2000) begin
			@(posedge sys_clk);
			c++;
		end
	endtask
	task automatic end_of_test();
		$display("err_total %0d samples_checked %0d", err_total,
			samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		#100us;
		err_total++;
		end_of_test();
	end
	initial begin
		int c;
		err_total = 0;
		samples_checked = 0;
		req = '0;
		req.hsel = 1'b1;
		req.hready = 1'b1;
		req.hsize = 3'h2;
		resetn = 1'b0;
		fuse = 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		poll(A_CTL, "ctrl_precal", 32'hffffffff, 32'h00010000);
		poll(A_CTL, "ctrl_rst", 32'hffffffff, 32'h00010080);
		chk("cal_req", 32'h0, 32'(cal_req));
		poll(A_SF, "flags_rst", 32'hffffffff, 32'h00000003);
		poll(wwdg_pkg::OFS_MODULE_REVISION, "rev", 32'hffffffff,
			wwdg_pkg::REVISION_VALUE);
		poll(12'h010, "unmapped", 32'hffffffff, 32'h00000000);
		wr(A_CTL, 32'haa000004);
		wr(A_CTL, 32'h55000004);
		wr(A_CTL, 32'haa000104);
		poll(A_CTL, "ctrl_nokey", 32'hffffffff, 32'h00010080);
		key(A_CTL, W[23:0]);
		poll(A_CTL, "ctrl_win", 32'hffffffff, W);
		key(A_CTL, W[23:0] | 24'h000003);
		poll(A_CTL, "en_on", 32'h00000001, 32'h00000001);
		key(A_CTL, (W[23:0] | 24'h000003) & 24'hfffffb);
		poll(A_CTL, "mode_hold", 32'hffffffff, W | 32'h3);
		poll(A_SF, "ban_flag", 32'hffffffff, 32'h00000002);
		key(A_CLR, 24'h000001);
		to_trip(c);
		chk("ban_trip", 32'h1, 32'(c < 3 * RC_DIV));
		poll(A_CTL, "dar_off", 32'hffffffff, W | 32'h2);
		key(A_CTL, W[23:0] | 24'h000003);
		poll(A_SF, "win_flag", 32'h00000001, 32'h00000001);
		key(A_CLR, 24'h000000);
		poll(A_SF, "clr_zero", 32'hffffffff, 32'h00000003);
		key(A_CLR, 24'h000001);
		poll(A_SF, "win_clr", 32'hffffffff, 32'h00000002);
		to_trip(c);
		chk("total", 32'h1, 32'(c >= 45 * RC_DIV && c <= 48 * RC_DIV));
		poll(A_CTL, "trip_off", 32'hffffffff, W | 32'h2);
		key(A_CTL, 24'h010082);
		poll(A_CTL, "basic", 32'hffffffff, 32'h00010082);
		key(A_CTL, 24'h010083);
		to_trip(c);
		chk("basic_to", 32'h1, 32'(c >= RC_DIV && c <= 4 * RC_DIV));
		poll(A_CTL, "basic_off", 32'hffffffff, 32'h00010082);
		key(A_CTL, 24'h01008a);
		key(A_CTL, 24'h010182);
		poll(A_CTL, "locked", 32'hffffffff, 32'h0001008a);
		chk("trips", 32'h3, 32'(trips));
		resetn <= 1'b0;
		fuse <= 1'b1;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		key(A_CTL, 24'h011003);
		poll(A_CTL, "fuse", 32'hffffff7f, 32'h00011001);
		end_of_test();
	end
endmodule
`default_nettype wire
